/* File: dv/ecp_cpu_model.sv */
// Processor model that runs strobe bus cycles against the host port.
`default_nettype none

module ecp_cpu_model (
	input  wire logic               clk,
	input  wire logic               transfer_ack_oe,
	input  wire logic               data_oe,
	input  wire ecp_pkg::ecp_byte_t data_out,
	output var  logic               port_select_n,
	output var  logic               access_strobe_n,
	output var  logic               direction_rd_wr_n,
	output var  ecp_pkg::ecp_addr_t address,
	output var  ecp_pkg::ecp_byte_t data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	import ecp_pkg::*;
	// ====================
	// Bus drive
	// A released bus shows the inverse of its last value, and a read inverts it again, so a missed read drive shows the value from before the release.
	ecp_byte_t drv;
	assign data_in = data_oe ? data_out : drv;
	initial begin
		port_select_n = 1'b1;
		access_strobe_n = 1'b1;
		direction_rd_wr_n = 1'b1;
		address = 11'h000;
		drv = 8'h5A;
	end
	task automatic access(input logic rd, input ecp_addr_t a, input ecp_byte_t w, input int lag,
		output ecp_byte_t r, output logic ok);
		ok = 1'b0;
		repeat (lag + 1) @(posedge clk);
		port_select_n <= 1'b0;
		access_strobe_n <= 1'b0;
		direction_rd_wr_n <= rd;
		address <= a;
		drv <= rd ? ~drv : w;
		for (int i = 0; i < 40 && !ok; i++) begin
			@(posedge clk);
			ok = transfer_ack_oe === 1'b1;
		end
		r = data_in;
		port_select_n <= 1'b1;
		access_strobe_n <= 1'b1;
		drv <= ~drv;
		repeat (4) @(posedge clk);
	endtask : access
	task automatic stray(output logic ok);
		@(posedge clk);
		access_strobe_n <= 1'b0;
		direction_rd_wr_n <= 1'b0;
		drv <= 8'hA5;
		ok = 1'b1;
		repeat (12) begin
			@(posedge clk);
			ok &= (transfer_ack_oe === 1'b0) && (data_oe === 1'b0);
		end
		access_strobe_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : stray
endmodule : ecp_cpu_model

`default_nettype wire

/* File: dv/ecp_host_port_assertions.sv */
// Pin-level checker for the echo canceller host port.
`default_nettype none

module ecp_host_port_assertions (
	input wire logic clk,
	input wire logic reset,
	input wire logic device_reset_n,
	input wire logic port_select_n,
	input wire logic access_strobe_n,
	input wire logic direction_rd_wr_n,
	input wire logic data_oe,
	input wire logic transfer_ack_oe,
	input wire logic interrupt_request_oe,
	input wire logic int_event,
	input wire logic reg_wr_strobe,
	input wire logic low_power_standby,
	input wire logic port_ready
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// ====================
	// Init length counter
	logic [11:0] run;
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			run <= 12'h000;
		else if (!device_reset_n)
			run <= 12'h000;
		else if (run != 12'hFFF)
			run <= run + 12'h001;
	end
	// ====================
	// Properties
	property p_idle;
		port_select_n [*5] |-> !transfer_ack_oe && !data_oe;
	endproperty
	a_idle: assert property (p_idle) else $error("ack while deselected");
	property p_take;
		$rose(transfer_ack_oe) |-> !$past(port_select_n, 4) && !$past(access_strobe_n, 4);
	endproperty
	a_take: assert property (p_take) else $error("ack without access");
	property p_rd;
		$rose(data_oe) |-> transfer_ack_oe && $past(direction_rd_wr_n, 2);
	endproperty
	a_rd: assert property (p_rd) else $error("bus driven outside read");
	property p_wr;
		reg_wr_strobe |-> ##[1:3] transfer_ack_oe && !data_oe;
	endproperty
	a_wr: assert property (p_wr) else $error("write not acknowledged");
	property p_rel;
		access_strobe_n [*5] |-> !transfer_ack_oe && !data_oe;
	endproperty
	a_rel: assert property (p_rel) else $error("ack held after strobe");
	property p_irq;
		int_event && port_ready |-> ##[1:3] interrupt_request_oe;
	endproperty
	a_irq: assert property (p_irq) else $error("irq not raised");
	property p_irq_clr;
		$fell(interrupt_request_oe) && device_reset_n |-> data_oe;
	endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("irq dropped without read");
	property p_stby;
		!device_reset_n [*5] |-> low_power_standby && !port_ready;
	endproperty
	a_stby: assert property (p_stby) else $error("not in standby");
	property p_init;
		$rose(port_ready) |-> run >= 12'h800 && run <= 12'h810 && !low_power_standby;
	endproperty
	a_init: assert property (p_init) else $error("init length wrong");
endmodule : ecp_host_port_assertions

bind ecp_host_port ecp_host_port_assertions ecp_host_port_assertions_inst (
	.clk(clk), .reset(reset), .device_reset_n(device_reset_n),
	.port_select_n(port_select_n), .access_strobe_n(access_strobe_n),
	.direction_rd_wr_n(direction_rd_wr_n), .data_oe(data_oe),
	.transfer_ack_oe(transfer_ack_oe), .interrupt_request_oe(interrupt_request_oe),
	.int_event(int_event), .reg_wr_strobe(reg_wr_strobe),
	.low_power_standby(low_power_standby), .port_ready(port_ready));

`default_nettype wire

/* File: dv/ecp_host_port_test.sv */
// Self-checking bench for the echo canceller host port.
`default_nettype none
`include "ecp_map.svh"

module ecp_host_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	import ecp_pkg::*;
	logic clk, reset, device_reset_n, int_event, ok;
	logic port_select_n, access_strobe_n, direction_rd_wr_n, data_oe, transfer_ack_oe;
	logic interrupt_request_oe, reg_wr_strobe, low_power_standby, port_ready;
	ecp_addr_t address, reg_wr_addr;
	ecp_byte_t data_in, data_out, reg_wr_data, rd;
	ecp_chan_t int_channel;
	int mismatches, compares;
	ecp_host_port ecp_host_port_inst (.clk(clk), .reset(reset), .device_reset_n(device_reset_n),
		.port_select_n(port_select_n), .access_strobe_n(access_strobe_n),
		.direction_rd_wr_n(direction_rd_wr_n), .address(address), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .transfer_ack_oe(transfer_ack_oe),
		.interrupt_request_oe(interrupt_request_oe), .int_event(int_event),
		.int_channel(int_channel), .reg_wr_strobe(reg_wr_strobe), .reg_wr_addr(reg_wr_addr),
		.reg_wr_data(reg_wr_data), .low_power_standby(low_power_standby), .port_ready(port_ready));
	ecp_cpu_model ecp_cpu_model_inst (.clk(clk), .transfer_ack_oe(transfer_ack_oe),
		.data_oe(data_oe), .data_out(data_out), .port_select_n(port_select_n),
		.access_strobe_n(access_strobe_n), .direction_rd_wr_n(direction_rd_wr_n),
		.address(address), .data_in(data_in));
	// ====================
	// Checks and bus helpers
	task automatic chk_v(input logic [10:0] got, input logic [10:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask : chk_v
	task automatic chk_b(input logic got, input logic exp, input string what);
		chk_v({10'h000, got}, {10'h000, exp}, what);
	endtask : chk_b
	task automatic wr(input ecp_addr_t a, input ecp_byte_t w, input int lag);
		ecp_cpu_model_inst.access(1'b0, a, w, lag, rd, ok);
		chk_b(ok, 1'b1, "write ack");
	endtask : wr
	task automatic rd_chk(input ecp_addr_t a, input ecp_byte_t e);
		ecp_cpu_model_inst.access(1'b1, a, 8'h00, 0, rd, ok);
		chk_b(ok, 1'b1, "read ack");
		chk_v({3'h0, rd}, {3'h0, e}, "read data");
	endtask : rd_chk
	task automatic boot;
		for (int i = 0; i < 3000 && port_ready !== 1'b1; i++)
			@(posedge clk);
		chk_b(port_ready, 1'b1, "ready");
		chk_b(low_power_standby, 1'b0, "standby left");
	endtask : boot
	// ====================
	// Scenarios
	task automatic t_standby;
		repeat (8) @(posedge clk);
		chk_b(low_power_standby, 1'b1, "standby");
		chk_b(port_ready, 1'b0, "not ready");
		device_reset_n <= 1'b1;
		boot();
		rd_chk(11'h000, `ECP_REG_DEFAULT);
		rd_chk(11'h7FF, `ECP_REG_DEFAULT);
	endtask : t_standby
	task automatic t_regs;
		wr(11'h7FF, 8'hC3, 0);
		chk_v(reg_wr_addr, 11'h7FF, "wr addr");
		chk_v({3'h0, reg_wr_data}, 11'h0C3, "wr data");
		wr(11'h400, 8'h3C, 3);
		rd_chk(11'h7FF, 8'hC3);
		rd_chk(11'h400, 8'h3C);
		rd_chk(11'h3FF, 8'h00);
		ecp_cpu_model_inst.stray(ok);
		chk_b(ok, 1'b1, "ack while deselected");
		rd_chk(11'h3FF, 8'h00);
	endtask : t_regs
	task automatic t_irq;
		int_event <= 1'b1;
		int_channel <= 5'h03;
		@(posedge clk);
		int_channel <= 5'h11;
		@(posedge clk);
		int_event <= 1'b0;
		repeat (3) @(posedge clk);
		chk_b(interrupt_request_oe, 1'b1, "irq set");
		rd_chk(`ECP_ADDR_IRQ_FIFO, `ECP_FIFO_VALID | 8'h03);
		chk_b(interrupt_request_oe, 1'b1, "irq held");
		rd_chk(`ECP_ADDR_IRQ_FIFO, `ECP_FIFO_VALID | 8'h11);
		chk_b(interrupt_request_oe, 1'b0, "irq released");
		rd_chk(`ECP_ADDR_IRQ_FIFO, `ECP_FIFO_EMPTY_RD);
		// A write to the interrupt FIFO address is acknowledged but changes nothing.
		wr(`ECP_ADDR_IRQ_FIFO, 8'hFF, 0);
		chk_v(reg_wr_addr, 11'h400, "fifo write ignored");
		chk_b(interrupt_request_oe, 1'b0, "irq after fifo write");
		rd_chk(`ECP_ADDR_IRQ_FIFO, `ECP_FIFO_EMPTY_RD);
	endtask : t_irq
	task automatic t_devreset;
		int_event <= 1'b1;
		@(posedge clk);
		int_event <= 1'b0;
		device_reset_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk_b(low_power_standby, 1'b1, "standby");
		chk_b(interrupt_request_oe, 1'b0, "irq cleared");
		device_reset_n <= 1'b1;
		boot();
		rd_chk(11'h7FF, `ECP_REG_DEFAULT);
	endtask : t_devreset
	task automatic end_of_test;
		if (mismatches == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		reset = 1'b1;
		device_reset_n = 1'b0;
		int_event = 1'b0;
		int_channel = 5'h00;
		mismatches = 0;
		compares = 0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		t_standby();
		t_regs();
		@(posedge clk);
		t_irq();
		t_devreset();
		end_of_test();
	end
	initial begin
		#200000;
		mismatches++;
		end_of_test();
	end
endmodule : ecp_host_port_test

`default_nettype wire

/* File: rtl/ecp_host_port.sv */
// Asynchronous strobe host port with register file, interrupt FIFO and device reset handling.
// Operation
// - Select high means every bus activity is ignored.
// - Access happens only while strobe and select are both low.
// - Direction picks read (drive data bus) or write (sample it).
// - Open-drain acknowledge is pulled low when the transfer completes.
// - Data path is one byte on one shared bidirectional bus.
// - Eleven address bits select one internal register.
// - Interrupt request is pulled low when any channel raises an event.
// - Interrupt request releases after the interrupt FIFO is read empty, or while device reset is held low.
// - Device reset low holds the port in reset and low-power standby.
// - On reset release, every register is loaded with its default value.
`default_nettype none
`include "ecp_map.svh"

module ecp_host_port (
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire logic               device_reset_n,
	input  wire logic               port_select_n,
	input  wire logic               access_strobe_n,
	input  wire logic               direction_rd_wr_n,
	input  wire ecp_pkg::ecp_addr_t address,
	input  wire ecp_pkg::ecp_byte_t data_in,
	output var  ecp_pkg::ecp_byte_t data_out,
	output var  logic               data_oe,
	output var  logic               transfer_ack_oe,
	output var  logic               interrupt_request_oe,
	input  wire logic               int_event,
	input  wire ecp_pkg::ecp_chan_t int_channel,
	output var  logic               reg_wr_strobe,
	output var  ecp_pkg::ecp_addr_t reg_wr_addr,
	output var  ecp_pkg::ecp_byte_t reg_wr_data,
	output var  logic               low_power_standby,
	output var  logic               port_ready
);
	import ecp_pkg::*;

	// ======================================================================
	// Pin synchronisers
	// ======================================================================
	logic      rst_s1, rst_s2;
	logic      sel_s1, sel_s2;
	logic      strb_s1, strb_s2;
	logic      dir_s1, dir_s2;
	ecp_addr_t addr_s1, addr_s2;
	ecp_byte_t data_s1, data_s2;

	// Strobe and select idle high so a reset never looks like an access.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rst_s1  <= 1'b0;
			rst_s2  <= 1'b0;
			sel_s1  <= 1'b1;
			sel_s2  <= 1'b1;
			strb_s1 <= 1'b1;
			strb_s2 <= 1'b1;
			dir_s1  <= 1'b1;
			dir_s2  <= 1'b1;
			addr_s1 <= '0;
			addr_s2 <= '0;
			data_s1 <= '0;
			data_s2 <= '0;
		end else begin
			rst_s1  <= device_reset_n;
			rst_s2  <= rst_s1;
			sel_s1  <= port_select_n;
			sel_s2  <= sel_s1;
			strb_s1 <= access_strobe_n;
			strb_s2 <= strb_s1;
			dir_s1  <= direction_rd_wr_n;
			dir_s2  <= dir_s1;
			addr_s1 <= address;
			addr_s2 <= addr_s1;
			data_s1 <= data_in;
			data_s2 <= data_s1;
		end
	end

	logic sel_act;
	assign sel_act = ~sel_s2 & ~strb_s2;

	// ======================================================================
	// Access sequencer
	// ======================================================================
	ecp_state_t state;
	ecp_addr_t  init_cnt;
	ecp_addr_t  addr_q;
	ecp_byte_t  wdata_q;
	logic       rd_q;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= ECP_S_STANDBY;
		end else if (!rst_s2) begin
			state <= ECP_S_STANDBY;
		end else begin
			case (state)
				ECP_S_STANDBY: begin
					state <= ECP_S_INIT;
				end
				ECP_S_INIT: begin
					if (init_cnt == `ECP_INIT_LAST) begin
						state <= ECP_S_IDLE;
					end
				end
				ECP_S_IDLE: begin
					if (sel_act) begin
						state <= ECP_S_ISSUE;
					end
				end
				ECP_S_ISSUE: begin
					state <= sel_act ? ECP_S_CAPTURE : ECP_S_IDLE;
				end
				ECP_S_CAPTURE: begin
					state <= sel_act ? ECP_S_ACK : ECP_S_IDLE;
				end
				ECP_S_ACK: begin
					if (!sel_act) begin
						state <= ECP_S_IDLE;
					end
				end
				default: begin
					state <= ECP_S_STANDBY;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			init_cnt <= `ECP_INIT_FIRST;
		end else if (state == ECP_S_INIT) begin
			init_cnt <= init_cnt + 11'h001;
		end else begin
			init_cnt <= `ECP_INIT_FIRST;
		end
	end

	// Request fields are taken once, when the access is first seen.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			addr_q  <= '0;
			wdata_q <= '0;
			rd_q    <= 1'b1;
		end else if (state == ECP_S_IDLE && sel_act) begin
			addr_q  <= addr_s2;
			wdata_q <= data_s2;
			rd_q    <= dir_s2;
		end
	end

	// ======================================================================
	// Register memory
	// ======================================================================
	logic      fifo_sel;
	logic      mem_we;
	ecp_addr_t mem_addr;
	ecp_byte_t mem_wdata;
	ecp_byte_t mem_rdata;

	assign fifo_sel  = (addr_q == `ECP_ADDR_IRQ_FIFO);
	assign mem_we    = (state == ECP_S_INIT) || (state == ECP_S_ISSUE && sel_act && !rd_q && !fifo_sel);
	assign mem_addr  = (state == ECP_S_INIT) ? init_cnt : addr_q;
	assign mem_wdata = (state == ECP_S_INIT) ? `ECP_REG_DEFAULT : wdata_q;

	ecp_reg_mem u_mem (
		.clk   (clk),
		.we    (mem_we),
		.addr  (mem_addr),
		.wdata (mem_wdata),
		.rdata (mem_rdata)
	);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			reg_wr_strobe <= 1'b0;
			reg_wr_addr   <= '0;
			reg_wr_data   <= '0;
		end else begin
			reg_wr_strobe <= mem_we && (state == ECP_S_ISSUE);
			if (mem_we && state == ECP_S_ISSUE) begin
				reg_wr_addr <= addr_q;
				reg_wr_data <= wdata_q;
			end
		end
	end

	// ======================================================================
	// Interrupt FIFO
	// ======================================================================
	ecp_chan_t                 fifo_mem [0:`ECP_FIFO_DEPTH-1];
	logic [`ECP_FIFO_PTR_W-1:0] wr_ptr, rd_ptr;
	logic [`ECP_FIFO_CNT_W-1:0] count, next_count;
	logic                      push, pop;

	assign pop  = (state == ECP_S_CAPTURE) && sel_act && rd_q && fifo_sel && (count != '0);
	// A full FIFO still accepts an event in the cycle that it is popped.
	assign push = int_event && rst_s2 && ((count != `ECP_FIFO_DEPTH) || pop);

	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + 4'h1;
		end else if (pop && !push) begin
			next_count = count - 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			fifo_mem[wr_ptr] <= int_channel;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else if (!rst_s2) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 3'h1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 3'h1;
			end
			count <= next_count;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			interrupt_request_oe <= 1'b0;
		end else begin
			interrupt_request_oe <= (next_count != '0) && rst_s2;
		end
	end

	// ======================================================================
	// Pin drivers
	// ======================================================================
	logic next_ack;
	assign next_ack = rst_s2 && sel_act && (state == ECP_S_CAPTURE || state == ECP_S_ACK);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			transfer_ack_oe <= 1'b0;
			data_oe         <= 1'b0;
		end else begin
			transfer_ack_oe <= next_ack;
			data_oe         <= next_ack && rd_q;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			data_out <= '0;
		end else if (state == ECP_S_CAPTURE && rd_q) begin
			if (!fifo_sel) begin
				data_out <= mem_rdata;
			end else if (count != '0) begin
				data_out <= `ECP_FIFO_VALID | {3'h0, fifo_mem[rd_ptr]};
			end else begin
				data_out <= `ECP_FIFO_EMPTY_RD;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			low_power_standby <= 1'b1;
			port_ready        <= 1'b0;
		end else begin
			low_power_standby <= !rst_s2 || state == ECP_S_STANDBY;
			port_ready        <= rst_s2 && state != ECP_S_STANDBY && state != ECP_S_INIT;
		end
	end

endmodule : ecp_host_port

`default_nettype wire

/* File: rtl/ecp_reg_mem.sv */
// Single-port register memory with a registered read data output.
`default_nettype none
`include "ecp_map.svh"

module ecp_reg_mem (
	input  wire logic              clk,
	input  wire logic              we,
	input  wire ecp_pkg::ecp_addr_t addr,
	input  wire ecp_pkg::ecp_byte_t wdata,
	output var  ecp_pkg::ecp_byte_t rdata
);
	import ecp_pkg::*;

	ecp_byte_t mem [0:`ECP_REG_DEPTH-1];

	// No reset on the array; the init sweep after reset writes every word.
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end

endmodule : ecp_reg_mem

`default_nettype wire

/* File: shared/ecp_map.svh */
// Constants for the echo canceller host port: widths, addresses, defaults and counts.
`ifndef ECP_MAP_SVH
`define ECP_MAP_SVH

// ==========================================================================
// Bus widths and register depth
// ==========================================================================
`define ECP_ADDR_W        11
`define ECP_DATA_W        8
`define ECP_REG_DEPTH     2048
`define ECP_CH_W          5

// ==========================================================================
// Address map and defaults
// ==========================================================================
`define ECP_ADDR_IRQ_FIFO 11'h020
`define ECP_REG_DEFAULT   8'h00
`define ECP_INIT_FIRST    11'h000
`define ECP_INIT_LAST     11'h7FF

// ==========================================================================
// Interrupt FIFO
// ==========================================================================
`define ECP_FIFO_DEPTH    4'h8
`define ECP_FIFO_PTR_W    3
`define ECP_FIFO_CNT_W    4
`define ECP_FIFO_VALID    8'h80
`define ECP_FIFO_EMPTY_RD 8'h00

`endif

/* File: shared/ecp_pkg.sv */
// Types shared by the echo canceller host port design files.
`default_nettype none

package ecp_pkg;

	typedef logic [10:0] ecp_addr_t;
	typedef logic [7:0]  ecp_byte_t;
	typedef logic [4:0]  ecp_chan_t;

	// Gray codes along standby, init, idle, issue, capture, ack.
	typedef enum logic [2:0] {
		ECP_S_STANDBY = 3'h5,
		ECP_S_INIT    = 3'h4,
		ECP_S_IDLE    = 3'h0,
		ECP_S_ISSUE   = 3'h1,
		ECP_S_CAPTURE = 3'h3,
		ECP_S_ACK     = 3'h2
	} ecp_state_t;

endpackage : ecp_pkg

`default_nettype wire
